// ### hdl/xtse_defines.svh
// constants for the xor / direction-load / subtract execution block
`ifndef XTSE_DEFINES_SVH
`define XTSE_DEFINES_SVH
`define XTSE_DIRLD_HI_MASK 12'hff8
`define XTSE_DIRLD_HI_VAL 12'h000
`define XTSE_DIRLD_MIN 3'h5
`define XTSE_XORLIT_OP 4'hf
`define XTSE_XORF_OP 6'h06
`define XTSE_SUBF_OP 6'h02
`define XTSE_DEST_BIT 5
`define XTSE_ACC_RESET 8'h00
`define XTSE_DIR_RESET 8'hff
`define XTSE_FILE_RESET 8'h00
`endif

// ### hdl/xtse_pkg.sv
// types for the xor / direction-load / subtract execution block
package xtse_pkg;
  typedef enum {
    XTSE_OP_NONE,
    XTSE_OP_DIRLD,
    XTSE_OP_XORLIT,
    XTSE_OP_XORF,
    XTSE_OP_SUBF
  } xtse_op_t;

  typedef struct packed {
    logic [7:0] value;
    logic zero;
    logic carry;
    logic to_file;
    logic [4:0] file_addr;
    logic [2:0] dir_sel;
  } xtse_dec_t;

  typedef struct packed {
    logic carry;
    logic zero;
  } xtse_flags_t;
endpackage

// ### hdl/xtse_decode.sv
// instruction word decoder for the execution block
`timescale 1ns/1ns
`include "xtse_defines.svh"
module xtse_decode (
  input wire logic [11:0] instr_in,
  output xtse_pkg::xtse_op_t op_out,
  output logic [7:0] literal_out,
  output logic [4:0] file_addr_out,
  output logic to_file_out,
  output logic [2:0] dir_sel_out
);
  import xtse_pkg::*;

  always_comb begin
    op_out = XTSE_OP_NONE;
    if ((instr_in & `XTSE_DIRLD_HI_MASK) == `XTSE_DIRLD_HI_VAL &&
        instr_in[2:0] >= `XTSE_DIRLD_MIN) begin
      op_out = XTSE_OP_DIRLD;
    end else if (instr_in[11:8] == `XTSE_XORLIT_OP) begin
      op_out = XTSE_OP_XORLIT;
    end else if (instr_in[11:6] == `XTSE_XORF_OP) begin
      op_out = XTSE_OP_XORF;
    end else if (instr_in[11:6] == `XTSE_SUBF_OP) begin
      op_out = XTSE_OP_SUBF;
    end
  end

  assign literal_out = instr_in[7:0];
  assign to_file_out = instr_in[`XTSE_DEST_BIT];
  assign file_addr_out = instr_in[4:0];
  assign dir_sel_out = instr_in[2:0];
endmodule

// ### hdl/xtse_exec.sv
// execution of direction-load, literal xor, file xor and file-minus-accumulator
`timescale 1ns/1ns
`include "xtse_defines.svh"
module xtse_exec #(
  parameter int FILE_DEPTH = 32
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic instr_valid_in,
  input wire logic [11:0] instr_in,
  output xtse_pkg::xtse_dec_t result_out,
  output logic [7:0] acc_out,
  output xtse_pkg::xtse_flags_t flags_out,
  output logic [7:0] dir5_out,
  output logic [7:0] dir6_out,
  output logic [7:0] dir7_out,
  output logic file_we_out,
  output logic [4:0] file_waddr_out,
  output logic [7:0] file_wdata_out
);
  import xtse_pkg::*;

  xtse_op_t op;
  logic [7:0] literal;
  logic [4:0] faddr;
  logic to_file;
  logic [2:0] dir_sel;
  logic [7:0] file_reg [FILE_DEPTH];
  logic [7:0] fval;
  logic [7:0] xor_val;
  logic [8:0] diff;
  logic [7:0] acc_reg;
  logic zero_reg;
  logic carry_reg;

  xtse_decode u_dec (
    .instr_in(instr_in),
    .op_out(op),
    .literal_out(literal),
    .file_addr_out(faddr),
    .to_file_out(to_file),
    .dir_sel_out(dir_sel)
  );

  assign fval = file_reg[faddr];
  assign xor_val = (op == XTSE_OP_XORLIT) ? (acc_reg ^ literal) : (acc_reg ^ fval);
  // 9-bit difference: msb is the borrow, carry is its inverse
  assign diff = {1'b0, fval} - {1'b0, acc_reg};

  // accumulator
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_reg <= `XTSE_ACC_RESET;
    end else if (instr_valid_in) begin
      case (op)
        XTSE_OP_XORLIT: acc_reg <= xor_val;
        XTSE_OP_XORF: if (!to_file) acc_reg <= xor_val;
        XTSE_OP_SUBF: if (!to_file) acc_reg <= diff[7:0];
        default: acc_reg <= acc_reg;
      endcase
    end
  end

  // status flags
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      zero_reg <= 1'b0;
      carry_reg <= 1'b0;
    end else if (instr_valid_in) begin
      case (op)
        XTSE_OP_XORLIT, XTSE_OP_XORF: zero_reg <= (xor_val == 8'h00);
        XTSE_OP_SUBF: begin
          zero_reg <= (diff[7:0] == 8'h00);
          carry_reg <= ~diff[8];
        end
        default: zero_reg <= zero_reg;
      endcase
    end
  end

  // file registers; reads are combinational from the array
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_reg[i] <= `XTSE_FILE_RESET;
      end
    end else if (instr_valid_in && to_file) begin
      if (op == XTSE_OP_XORF) begin
        file_reg[faddr] <= xor_val;
      end else if (op == XTSE_OP_SUBF) begin
        file_reg[faddr] <= diff[7:0];
      end
    end
  end

  // write port mirror for the rest of the core
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      file_we_out <= 1'b0;
      file_waddr_out <= 5'h00;
      file_wdata_out <= 8'h00;
    end else begin
      file_we_out <= instr_valid_in && to_file &&
                     (op == XTSE_OP_XORF || op == XTSE_OP_SUBF);
      file_waddr_out <= faddr;
      file_wdata_out <= (op == XTSE_OP_SUBF) ? diff[7:0] : xor_val;
    end
  end

  // direction registers; reset to all inputs
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dir5_out <= `XTSE_DIR_RESET;
      dir6_out <= `XTSE_DIR_RESET;
      dir7_out <= `XTSE_DIR_RESET;
    end else if (instr_valid_in && op == XTSE_OP_DIRLD) begin
      case (dir_sel)
        3'h5: dir5_out <= acc_reg;
        3'h6: dir6_out <= acc_reg;
        3'h7: dir7_out <= acc_reg;
        default: dir5_out <= dir5_out;
      endcase
    end
  end

  // last executed result, for observation
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_out <= '0;
    end else if (instr_valid_in && op != XTSE_OP_NONE) begin
      result_out.value <= (op == XTSE_OP_SUBF) ? diff[7:0] :
                          (op == XTSE_OP_DIRLD) ? acc_reg : xor_val;
      result_out.zero <= (op == XTSE_OP_SUBF) ? (diff[7:0] == 8'h00) : (xor_val == 8'h00);
      result_out.carry <= (op == XTSE_OP_SUBF) ? ~diff[8] : carry_reg;
      result_out.to_file <= to_file;
      result_out.file_addr <= faddr;
      result_out.dir_sel <= dir_sel;
    end
  end

  assign acc_out = acc_reg;
  assign flags_out = '{carry: carry_reg, zero: zero_reg};
endmodule

// ### dv/xtse_chk.sv
// assertions on the ports of the execution block
`timescale 1ns/1ns
module xtse_chk (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic instr_valid_in,
  input wire logic [11:0] instr_in,
  input xtse_pkg::xtse_flags_t flags_out,
  input wire logic [7:0] acc_out,
  input wire logic [7:0] dir5_out,
  input wire logic file_we_out,
  input wire logic [4:0] file_waddr_out,
  input wire logic [7:0] file_wdata_out
);
  import xtse_pkg::*;
  wire v = instr_valid_in;
  wire [11:0] i = instr_in;
  wire xr = v && (i[11:8] == 4'hf || i[11:6] == 6'h06);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  a_dir_load: assert property (v && i == 12'h005 |=> dir5_out == $past(acc_out))
    else $error("dir load");
  a_dir_refused: assert property (v && i == 12'h004 |=> $stable(dir5_out))
    else $error("dir refused");
  a_xlit_acc: assert property (v && i[11:8] == 4'hf
    |=> acc_out == ($past(acc_out) ^ $past(instr_in[7:0]))) else $error("xlit");
  // d=1 result only shows on the write port
  a_xor_zero: assert property (xr
    |=> flags_out.zero == ((file_we_out ? file_wdata_out : acc_out) == 8'h00))
    else $error("xor zero");
  a_xor_carry: assert property (xr |=> $stable(flags_out.carry))
    else $error("xor carry");
  a_xorf_file: assert property (v && i[11:5] == 7'h0d |=> file_we_out &&
    file_waddr_out == $past(instr_in[4:0]) && $stable(acc_out)) else $error("xorf file");
  a_xorf_acc: assert property (v && i[11:5] == 7'h0c |=> !file_we_out)
    else $error("xorf acc");
  // carry set exactly when result + acc does not wrap
  a_sub_carry: assert property (v && i[11:5] == 7'h05 |=> flags_out.carry ==
    (9'(file_wdata_out) + 9'($past(acc_out)) < 9'h100)) else $error("sub carry");
endmodule
bind xtse_exec xtse_chk u_chk (.clock_in, .nrst_in, .instr_valid_in, .instr_in,
  .flags_out, .acc_out, .dir5_out, .file_we_out, .file_waddr_out, .file_wdata_out);

// ### dv/testbench.sv
// directed tests for the execution block
`timescale 1ns/1ns
module testbench;
  import xtse_pkg::*;
  logic clock_in = 0, nrst_in = 0, instr_valid_in = 0;
  logic [11:0] instr_in = 12'h000;
  xtse_flags_t f;
  xtse_dec_t r;
  logic [7:0] a, d5, d6, d7, wd;
  logic we;
  logic [4:0] wa;
  int num_errors = 0, n_checks = 0;
  always #2 clock_in = ~clock_in;
  xtse_exec u_xtse_exec (.clock_in, .nrst_in, .instr_valid_in, .instr_in, .result_out(r),
    .acc_out(a), .flags_out(f), .dir5_out(d5), .dir6_out(d6), .dir7_out(d7),
    .file_we_out(we), .file_waddr_out(wa), .file_wdata_out(wd));
  task chk(input string n, input logic [7:0] s, e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // one instruction, results settled at the next falling edge
  task ex(input logic [11:0] w);
    @(negedge clock_in);
    instr_valid_in = 1;
    instr_in = w;
    @(negedge clock_in);
    instr_valid_in = 0;
  endtask
  task seta(input logic [7:0] v);
    ex({4'hf, a ^ v});
  endtask
  task t_xlit;
    seta(8'hb5);
    ex(12'hfaf);
    chk("acc", a, 8'h1a);
    chk("z", 8'(f.zero), 8'h00);
    ex(12'hf1a);
    chk("z", 8'(f.zero), 8'h01);
    $display("xlit done");
  endtask
  task t_dir;
    for (int s = 5; s < 8; s++) begin
      seta(8'h50 + 8'(s));
      ex(12'(s));
    end
    seta(8'h11);
    ex(12'h004);
    ex(12'h000);
    chk("d5", d5, 8'h55);
    chk("d6", d6, 8'h56);
    chk("d7", d7, 8'h57);
    $display("dir done");
  endtask
  task t_xorf;
    seta(8'haf);
    ex(12'h1a3);
    chk("we", 8'(we), 8'h01);
    chk("wa", 8'(wa), 8'h03);
    chk("acc", a, 8'haf);
    seta(8'hb5);
    ex(12'h1a3);
    chk("wd", wd, 8'h1a);
    ex(12'h183);
    chk("acc", a, 8'haf);
    chk("we", 8'(we), 8'h00);
    seta(8'h1a);
    ex(12'h183);
    chk("z", 8'(f.zero), 8'h01);
    $display("xorf done");
  endtask
  task t_sub;
    seta(8'h03);
    ex(12'h1a4);
    seta(8'h02);
    ex(12'h0a4);
    chk("c", 8'(f.carry), 8'h01);
    chk("rv", r.value, 8'h01);
    chk("rc", 8'(r.carry), 8'h01);
    ex(12'h0a4);
    chk("wd", wd, 8'hff);
    chk("c", 8'(f.carry), 8'h00);
    seta(8'hff);
    ex(12'h0a4);
    chk("c", 8'(f.carry), 8'h01);
    ex(12'hf00);
    chk("c", 8'(f.carry), 8'h01);
    ex(12'h084);
    chk("acc", a, 8'h01);
    chk("c", 8'(f.carry), 8'h00);
    chk("rv", r.value, 8'h01);
    $display("sub done");
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #4000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(negedge clock_in);
    nrst_in = 1;
    t_xlit;
    t_dir;
    t_xorf;
    t_sub;
    report_and_stop;
  end
endmodule
